// ### src/arop_top.v
// Result output port of a sampling converter: parallel bus or serial
// link (internal or external clock) on shared data pins, plus a
// Wishbone slave holding mode control, status and the last result.
// Assumes conv_busy/conv_done/conv_result come from the core on mclk,
// and that cs_n, rd_n and the external serial clock arrive from pins.
`timescale 1ns/1ns
`include "arop_defines.vh"

module arop_top #(
  parameter RES_W = `AROP_RESULT_BITS
) (
  input wire mclk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire conv_busy,
  input wire conv_done,
  input wire [RES_W-1:0] conv_result,
  input wire cs_n_pin,
  input wire rd_n_pin,
  input wire serial_result_clock_in,
  output wire busy_out,
  output wire read_overrun_flag,
  output wire [RES_W-1:0] d_out,
  output wire [RES_W-1:0] d_oe_n
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_LEAD = 2'b01;
  localparam [1:0] ST_HIGH = 2'b10;
  localparam [1:0] ST_LOW = 2'b11;

  localparam integer FAST_I = `AROP_FAST_HALF_CYC;
  localparam integer SLOW_I = `AROP_SLOW_HALF_CYC;
  localparam integer DIV_I = `AROP_DIV_HALF_CYC;
  localparam integer FBITS_I = `AROP_FAST_BITS;
  localparam integer RES_I = RES_W;
  localparam [7:0] FAST_HALF = FAST_I[7:0];
  localparam [7:0] SLOW_HALF = SLOW_I[7:0];
  localparam [7:0] DIV_HALF = DIV_I[7:0];
  localparam [4:0] FAST_BITS = FBITS_I[4:0];
  localparam [4:0] ALL_BITS = RES_I[4:0];

  reg [7:0] ctrl_reg;
  reg [RES_W-1:0] result_reg;
  reg [RES_W-1:0] shift_reg;
  reg [4:0] bit_cnt_reg;
  reg [1:0] state_reg;
  reg [7:0] tick_reg;
  reg sclk_reg;
  reg frame_reg;
  reg hold_busy_reg;
  reg ovr_sticky_reg;
  reg ovr_pulse_reg;
  reg busy_d_reg;
  reg ext_idle_reg;
  reg ext_prev_reg;
  reg sel_d_reg;
  reg ack_reg;
  reg [31:0] dat_o_reg;
  reg [RES_W-1:0] pin_out_reg;
  reg [RES_W-1:0] pin_oe_n_reg;
  reg [RES_W-1:0] pin_out_next;
  reg [RES_W-1:0] pin_oe_n_next;
  reg [31:0] rd_next;

  wire [2:0] sync_v;
  wire cs_n_s;
  wire rd_n_s;
  wire sclk_s;
  wire sel;
  wire link_ser;
  wire byte_swap;
  wire ext_clk;
  wire sclk_inv;
  wire frame_inv;
  wire read_during_conversion_sel;
  wire [1:0] div;
  wire int_mode;
  wire ext_mode;
  wire conv_start;
  wire wb_hit;
  wire wb_wr;
  wire ovr_event;
  wire pulse_end;

  // Half period of the current bit in internal clock mode
  function [7:0] half_cycles;
    input rdc_f;
    input [1:0] div_f;
    input [4:0] left_f;
    begin
      if (rdc_f) begin
        if ((ALL_BITS - left_f) < FAST_BITS)
          half_cycles = FAST_HALF;
        else
          half_cycles = SLOW_HALF;
      end else begin
        half_cycles = DIV_HALF << div_f;
      end
    end
  endfunction

  arop_sync3 #(
    .W(3)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in({serial_result_clock_in, rd_n_pin, cs_n_pin}),
    .stable_out(sync_v)
  );

  assign cs_n_s = sync_v[0];
  assign rd_n_s = sync_v[1];
  assign sclk_s = sync_v[2];
  assign sel = ~cs_n_s & ~rd_n_s;

  assign link_ser = ctrl_reg[`AROP_CTRL_LINK];
  assign byte_swap = ctrl_reg[`AROP_CTRL_BYTE];
  assign ext_clk = ctrl_reg[`AROP_CTRL_CSRC];
  assign sclk_inv = ctrl_reg[`AROP_CTRL_SINV];
  assign frame_inv = ctrl_reg[`AROP_CTRL_FINV];
  assign read_during_conversion_sel = ctrl_reg[`AROP_CTRL_RDC];
  assign div = ctrl_reg[`AROP_CTRL_DIV_HI:`AROP_CTRL_DIV_LO];
  assign int_mode = link_ser & ~ext_clk;
  assign ext_mode = link_ser & ext_clk;

  assign conv_start = conv_busy & ~busy_d_reg;
  assign wb_hit = wb_cyc_i & wb_stb_i & ~ack_reg;
  // Writes land at the edge where the master samples ack high
  assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & ack_reg;
  // Previous result not fully shifted when the next one lands
  assign ovr_event = ext_mode & read_during_conversion_sel & conv_done & (bit_cnt_reg != 5'h00);
  // A pulse ends when the clock returns to its resting level
  assign pulse_end = sel & sel_d_reg & (sclk_s != ext_prev_reg) &
                     (sclk_s == ext_idle_reg);

  // Completed conversions only; a running one never disturbs this copy
  always @(posedge mclk) begin
    if (rst)
      result_reg <= {RES_W{1'b0}};
    else if (conv_done)
      result_reg <= conv_result;
  end

  // Serial shifter, clock maker and frame
  always @(posedge mclk) begin
    if (rst) begin
      shift_reg <= {RES_W{1'b0}};
      bit_cnt_reg <= 5'h00;
      state_reg <= ST_IDLE;
      tick_reg <= 8'h00;
      sclk_reg <= 1'b0;
      frame_reg <= 1'b0;
      hold_busy_reg <= 1'b0;
      busy_d_reg <= 1'b0;
      ext_idle_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      sel_d_reg <= 1'b0;
    end else begin
      busy_d_reg <= conv_busy;
      ext_prev_reg <= sclk_s;
      sel_d_reg <= sel;
      if (sel & ~sel_d_reg)
        ext_idle_reg <= sclk_s;
      if (int_mode) begin
        if (state_reg == ST_IDLE) begin
          if (read_during_conversion_sel ? conv_start : conv_done) begin
            shift_reg <= read_during_conversion_sel ? result_reg : conv_result;
            bit_cnt_reg <= ALL_BITS;
            state_reg <= ST_LEAD;
            tick_reg <= half_cycles(read_during_conversion_sel, div, ALL_BITS) - 8'h01;
            frame_reg <= 1'b1;
            hold_busy_reg <= ~read_during_conversion_sel;
          end
        end else if (tick_reg != 8'h00) begin
          tick_reg <= tick_reg - 8'h01;
        end else begin
          tick_reg <= half_cycles(read_during_conversion_sel, div, bit_cnt_reg) - 8'h01;
          case (state_reg)
            ST_LEAD: begin
              sclk_reg <= 1'b1;
              state_reg <= ST_HIGH;
            end
            ST_HIGH: begin
              sclk_reg <= 1'b0;
              state_reg <= ST_LOW;
            end
            ST_LOW: begin
              // Data moves mid-low, away from both clock edges
              shift_reg <= {shift_reg[RES_W-2:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg - 5'h01;
              if (bit_cnt_reg == 5'h01) begin
                state_reg <= ST_IDLE;
                frame_reg <= 1'b0;
                hold_busy_reg <= 1'b0;
              end else begin
                state_reg <= ST_LEAD;
              end
            end
            default: begin
              state_reg <= ST_IDLE;
            end
          endcase
        end
      end else begin
        state_reg <= ST_IDLE;
        sclk_reg <= 1'b0;
        frame_reg <= 1'b0;
        hold_busy_reg <= 1'b0;
        if (ext_mode & conv_done) begin
          shift_reg <= conv_result;
          bit_cnt_reg <= ALL_BITS;
        end else if (ext_mode & pulse_end & (bit_cnt_reg != 5'h00)) begin
          shift_reg <= {shift_reg[RES_W-2:0], 1'b0};
          bit_cnt_reg <= bit_cnt_reg - 5'h01;
        end
      end
    end
  end

  // Overrun: one-cycle pulse plus a sticky copy; a new event beats a clear
  always @(posedge mclk) begin
    if (rst) begin
      ovr_pulse_reg <= 1'b0;
      ovr_sticky_reg <= 1'b0;
    end else begin
      ovr_pulse_reg <= ovr_event;
      if (ovr_event)
        ovr_sticky_reg <= 1'b1;
      else if (wb_wr &
               (wb_adr_i[3:2] == `AROP_ADDR_STATUS) &
               wb_dat_i[`AROP_STAT_OVR])
        ovr_sticky_reg <= 1'b0;
    end
  end

  // Pin drive
  always @* begin
    pin_out_next = {RES_W{1'b0}};
    pin_oe_n_next = {RES_W{1'b1}};
    if (!link_ser) begin
      if (byte_swap) begin
        pin_out_next[7:0] = {{(16 - RES_W){1'b0}}, result_reg[RES_W-1:8]};
        pin_out_next[RES_W-1:8] = result_reg[RES_W-9:0];
      end else begin
        pin_out_next = result_reg;
      end
      pin_oe_n_next = {RES_W{1'b0}};
    end else begin
      pin_out_next[`AROP_PIN_SERIAL_RESULT_OUT] = shift_reg[RES_W-1];
      pin_oe_n_next[`AROP_PIN_SERIAL_RESULT_OUT] = 1'b0;
      if (int_mode) begin
        pin_out_next[`AROP_PIN_SCLK] = sclk_reg ^ sclk_inv;
        pin_out_next[`AROP_PIN_FRAME] = frame_reg ^ frame_inv;
        pin_oe_n_next[`AROP_PIN_SCLK] = 1'b0;
        pin_oe_n_next[`AROP_PIN_FRAME] = 1'b0;
      end else begin
        pin_out_next[`AROP_PIN_OVR] = ovr_pulse_reg;
        pin_oe_n_next[`AROP_PIN_OVR] = 1'b0;
      end
      pin_oe_n_next[RES_W-1:RES_W-4] = 4'hF;
    end
    if (!sel)
      pin_oe_n_next = {RES_W{1'b1}};
  end

  always @(posedge mclk) begin
    if (rst) begin
      pin_out_reg <= {RES_W{1'b0}};
      pin_oe_n_reg <= {RES_W{1'b1}};
    end else begin
      pin_out_reg <= pin_out_next;
      pin_oe_n_reg <= pin_oe_n_next;
    end
  end

  // Register read data
  always @* begin
    rd_next = 32'h00000000;
    case (wb_adr_i[3:2])
      `AROP_ADDR_CTRL: begin
        rd_next[7:0] = ctrl_reg;
      end
      `AROP_ADDR_STATUS: begin
        rd_next[`AROP_STAT_BUSY] = busy_out;
        rd_next[`AROP_STAT_FRAME] = frame_reg;
        rd_next[`AROP_STAT_OVR] = ovr_sticky_reg;
        rd_next[`AROP_STAT_CNT_LO+4:`AROP_STAT_CNT_LO] = bit_cnt_reg;
      end
      `AROP_ADDR_RESULT: begin
        rd_next[RES_W-1:0] = result_reg;
      end
      default: begin
        rd_next = 32'h00000000;
      end
    endcase
  end

  // Wishbone slave: one wait state, unmapped reads return zero
  always @(posedge mclk) begin
    if (rst) begin
      ack_reg <= 1'b0;
      dat_o_reg <= 32'h00000000;
      ctrl_reg <= `AROP_CTRL_RESET;
    end else begin
      ack_reg <= wb_hit;
      if (wb_hit)
        dat_o_reg <= rd_next;
      if (wb_wr &
          (wb_adr_i[3:2] == `AROP_ADDR_CTRL))
        ctrl_reg <= wb_dat_i[7:0];
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_o_reg;
  assign busy_out = conv_busy | hold_busy_reg;
  assign read_overrun_flag = ovr_pulse_reg;
  assign d_out = pin_out_reg;
  assign d_oe_n = pin_oe_n_reg;

endmodule

// ### src/arop_defines.vh
// Constants for the converter result output port: register map, field
// positions, reset values, pin positions on the shared data bus, timing.
// Assumes a 100 MHz mclk; included by its bare name.
`ifndef AROP_DEFINES_VH
`define AROP_DEFINES_VH

`define AROP_CLK_NS 10
`define AROP_RESULT_BITS 14

// Word registers on the Wishbone bus, word indices compared with wb_adr_i[3:2]
`define AROP_ADDR_CTRL 2'h0
`define AROP_ADDR_STATUS 2'h1
`define AROP_ADDR_RESULT 2'h2

// Control register fields
`define AROP_CTRL_LINK 0
`define AROP_CTRL_BYTE 1
`define AROP_CTRL_CSRC 2
`define AROP_CTRL_SINV 3
`define AROP_CTRL_FINV 4
`define AROP_CTRL_RDC 5
`define AROP_CTRL_DIV_LO 6
`define AROP_CTRL_DIV_HI 7
`define AROP_CTRL_RESET 8'h00

// Status register fields
`define AROP_STAT_BUSY 0
`define AROP_STAT_FRAME 1
`define AROP_STAT_OVR 2
`define AROP_STAT_CNT_LO 4

// Serial signals on the data pins; pins 13..10 belong to the config port
`define AROP_PIN_SERIAL_RESULT_OUT 2
`define AROP_PIN_SCLK 3
`define AROP_PIN_FRAME 4
`define AROP_PIN_OVR 5

// Serial clock half periods
`define AROP_FAST_HALF_NS 20
`define AROP_SLOW_HALF_NS 40
`define AROP_DIV_HALF_NS 20
`define AROP_FAST_BITS 8
`define AROP_FAST_HALF_CYC ((`AROP_FAST_HALF_NS + `AROP_CLK_NS - 1) / `AROP_CLK_NS)
`define AROP_SLOW_HALF_CYC ((`AROP_SLOW_HALF_NS + `AROP_CLK_NS - 1) / `AROP_CLK_NS)
`define AROP_DIV_HALF_CYC ((`AROP_DIV_HALF_NS + `AROP_CLK_NS - 1) / `AROP_CLK_NS)

`endif

// ### src/arop_sync3.v
// Three-stage synchroniser for pin inputs.
// Assumes inputs come from outside mclk; a change is taken once the
// second and third stages agree.
`timescale 1ns/1ns

module arop_sync3 #(
  parameter W = 1
) (
  input wire mclk,
  input wire rst,
  input wire [W-1:0] async_in,
  output wire [W-1:0] stable_out
);

  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  reg [W-1:0] out_reg;

  always @(posedge mclk) begin
    if (rst) begin
      s1_reg <= {W{1'b1}};
      s2_reg <= {W{1'b1}};
      s3_reg <= {W{1'b1}};
      out_reg <= {W{1'b1}};
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Follow stages two and three once they agree, otherwise hold
      out_reg <= (s2_reg & s3_reg) | (out_reg & (s2_reg ^ s3_reg));
    end
  end

  assign stable_out = out_reg;

endmodule

// ### dv/arop_asserts.sv
// Checker for the result output port; sees only the top module's ports.
// Assumes control is written only while no conversion is in flight.
`timescale 1ns/1ns
module arop_asserts #(
  parameter RES_W = 14
) (
  input wire mclk,
  input wire rst,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire conv_busy,
  input wire conv_done,
  input wire [RES_W-1:0] conv_result,
  input wire cs_n_pin,
  input wire rd_n_pin,
  input wire busy_out,
  input wire read_overrun_flag,
  input wire [RES_W-1:0] d_out,
  input wire [RES_W-1:0] d_oe_n
);
  logic [7:0] ctrl_reg;
  logic [2:0] desel_reg;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Shadow of the control register, taken when the write is acknowledged
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_reg <= 8'h00;
    end else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[3:2] == 2'h0) begin
      ctrl_reg <= wb_dat_i[7:0];
    end
  end
  always_ff @(posedge mclk) begin
    if (rst || !(cs_n_pin || rd_n_pin)) begin
      desel_reg <= 3'h0;
    end else if (desel_reg != 3'h7) begin
      desel_reg <= desel_reg + 3'h1;
    end
  end
  property p_release;
    desel_reg == 3'h7 |-> &d_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("pins driven while deselected");
  property p_reset_idle;
    $fell(rst) |-> &d_oe_n && !wb_ack_o && !read_overrun_flag;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs active in reset");
  property p_par_value;
    !ctrl_reg[0] && !ctrl_reg[1] && conv_done |-> ##2 (|d_oe_n || d_out == $past(conv_result, 2));
  endproperty
  a_par_value: assert property (p_par_value) else $error("parallel value wrong");
  property p_swap;
    !ctrl_reg[0] && ctrl_reg[1] && conv_done |-> ##2 (|d_oe_n ||
      d_out == {$past(conv_result[5:0], 2), 2'h0, $past(conv_result[13:8], 2)});
  endproperty
  a_swap: assert property (p_swap) else $error("swapped value wrong");
  property p_upper_free;
    ctrl_reg[0] [*4] |-> d_oe_n[13:10] == 4'hF;
  endproperty
  a_upper_free: assert property (p_upper_free) else $error("config pins driven");
  property p_busy;
    conv_busy |-> busy_out;
  endproperty
  a_busy: assert property (p_busy) else $error("busy low in conversion");
  property p_busy_plain;
    !ctrl_reg[0] [*2] |-> busy_out == conv_busy;
  endproperty
  a_busy_plain: assert property (p_busy_plain) else $error("busy held in parallel mode");
  property p_hold;
    ctrl_reg[0] && !ctrl_reg[2] && !ctrl_reg[5] && conv_done |=> busy_out [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("busy dropped before bits sent");
  property p_overrun;
    read_overrun_flag |-> $past(conv_done) && ctrl_reg[2] && ctrl_reg[5] ##1 !read_overrun_flag;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun pulse wrong");
endmodule
bind arop_top arop_asserts #(.RES_W(RES_W)) arop_asserts_i (.mclk, .rst, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_ack_o, .conv_busy, .conv_done, .conv_result, .cs_n_pin, .rd_n_pin,
  .busy_out, .read_overrun_flag, .d_out, .d_oe_n);

// ### dv/arop_host.sv
// Host model: drives select, read and external clock pins, reads data pins.
// Assumes pins change just after mclk edges; a released line reads inverted.
`timescale 1ns/1ns
module arop_host (
  input wire mclk,
  input wire [13:0] d_out,
  input wire [13:0] d_oe_n,
  output logic cs_n,
  output logic rd_n,
  output logic sclk
);
  wire [13:0] pin = d_out ^ d_oe_n;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    sclk = 1'b0;
  end
  // Sets the clock rest level first, then selects or deselects
  task automatic pick(input logic on, input logic rest);
    @(posedge mclk);
    sclk <= rest;
    repeat (4) @(posedge mclk);
    cs_n <= !on;
    rd_n <= !on;
    repeat (8) @(posedge mclk);
  endtask
  task automatic ext_read(input logic rest, output logic [13:0] w);
    // Let the pins catch up with the last load or mode change
    repeat (2) @(posedge mclk);
    for (int i = 13; i >= 0; i--) begin
      w[i] = pin[2];
      @(posedge mclk);
      sclk <= !rest;
      repeat (6) @(posedge mclk);
      sclk <= rest;
      repeat (8) @(posedge mclk);
    end
  endtask
  task automatic int_read(input logic inv, output logic [13:0] wr, output logic [13:0] wf,
      output logic fr);
    // Pins lag a control write by one cycle; skip the stale levels
    repeat (2) @(posedge mclk);
    for (int i = 13; i >= 0; i--) begin
      while ((pin[3] ^ inv) !== 1'b1) @(posedge mclk);
      wr[i] = pin[2];
      if (i == 13) fr = pin[4];
      while ((pin[3] ^ inv) !== 1'b0) @(posedge mclk);
      wf[i] = pin[2];
    end
  endtask
endmodule

// ### dv/test_arop_top.sv
// Testbench for the result output port: bus tasks, row table, serial reads.
// Assumes the checker binds itself to the top module.
`timescale 1ns/1ns
module test_arop_top;
  logic mclk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, busy = 1'b0, done = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wd = 32'h0, rd;
  logic [13:0] res = 14'h0, e, w1, w2;
  logic fr;
  // Rows: byte order select, result, expected data pins
  logic [28:0] rows [4] = '{{1'b0, 14'h3FFF, 14'h3FFF}, {1'b1, 14'h0001, 14'h0100},
    {1'b0, 14'h2A5C, 14'h2A5C}, {1'b1, 14'h1234, 14'h3412}};
  wire [31:0] dat_o;
  wire [13:0] d_out, d_oe_n;
  wire ack, bsy, ovr, cs_n, rd_n, sclk;
  int miscompares = 0, n_checks = 0, ticks = 0;
  arop_top #(.RES_W(14)) arop_top_i (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .conv_busy(busy), .conv_done(done), .conv_result(res), .cs_n_pin(cs_n),
    .rd_n_pin(rd_n), .serial_result_clock_in(sclk), .busy_out(bsy), .read_overrun_flag(ovr),
    .d_out(d_out), .d_oe_n(d_oe_n));
  arop_host arop_host_i (.mclk(mclk), .d_out(d_out), .d_oe_n(d_oe_n), .cs_n(cs_n),
    .rd_n(rd_n), .sclk(sclk));
  initial begin
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    ticks <= ticks + 1;
    if (ticks == 30000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic test_done();
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      $display("ERROR %s expected %h seen %h", nm, ex, got);
      miscompares++;
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] v);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wd <= v;
    @(posedge mclk);
    while (ack !== 1'b1) @(posedge mclk);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic conv(input logic [13:0] r, input int n);
    @(posedge mclk);
    busy <= 1'b1;
    repeat (n) @(posedge mclk);
    done <= 1'b1;
    res <= r;
    @(posedge mclk);
    done <= 1'b0;
    busy <= 1'b0;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    wb(1'b1, 4'h0, 4'hE, 32'h1);
    wb(1'b1, 4'hC, 4'hF, 32'hFF);
    wb(1'b0, 4'hC, 4'hF, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'b0, 4'h0, 4'hF, 32'h0);
    chk("ctrl", 32'h0, rd);
    arop_host_i.pick(1'b1, 1'b0);
    foreach (rows[i]) begin
      wb(1'b1, 4'h0, 4'hF, {30'h0, rows[i][28], 1'b0});
      conv(rows[i][27:14], 5);
      repeat (3) @(posedge mclk);
      e = rows[i][13:0];
      chk("d_out", {18'h0, e}, {18'h0, d_out});
      chk("d_oe_n", 32'h0, {18'h0, d_oe_n});
      wb(1'b0, 4'h8, 4'hF, 32'h0);
      chk("result", {18'h0, rows[i][27:14]}, rd);
    end
    busy <= 1'b1;
    repeat (10) @(posedge mclk);
    chk("held", {18'h0, e}, {18'h0, d_out});
    busy <= 1'b0;
    arop_host_i.pick(1'b0, 1'b0);
    chk("released", 32'h3FFF, {18'h0, d_oe_n});
    arop_host_i.pick(1'b1, 1'b0);
    for (int d = 0; d < 4; d++) begin
      wb(1'b1, 4'h0, 4'hF, {24'h0, d[1:0], 1'b0, d[1], d[0], 3'h1});
      e = 14'h2C35 ^ d[13:0];
      fork
        conv(e, 5);
        arop_host_i.int_read(d[0], w1, w2, fr);
      join
      chk("int rise", {18'h0, e}, {18'h0, w1});
      chk("int fall", {18'h0, e}, {18'h0, w2});
      chk("frame", 32'h1, {31'h0, fr ^ d[1]});
      chk("busy held", 32'h1, {31'h0, bsy});
      repeat (40) @(posedge mclk);
      chk("busy free", 32'h0, {31'h0, bsy});
    end
    wb(1'b1, 4'h0, 4'hF, 32'h21);
    fork
      conv(14'h1C3A, 300);
      arop_host_i.int_read(1'b0, w1, w2, fr);
    join
    chk("int rdc", {18'h0, e}, {18'h0, w1});
    repeat (40) @(posedge mclk);
    wb(1'b1, 4'h0, 4'hF, 32'h05);
    conv(14'h2B6D, 5);
    arop_host_i.ext_read(1'b0, w1);
    chk("ext low", 32'h2B6D, {18'h0, w1});
    conv(14'h15A3, 5);
    arop_host_i.pick(1'b0, 1'b1);
    arop_host_i.pick(1'b1, 1'b1);
    arop_host_i.ext_read(1'b1, w1);
    chk("ext high", 32'h15A3, {18'h0, w1});
    wb(1'b1, 4'h0, 4'hF, 32'h25);
    conv(14'h0ABC, 5);
    conv(14'h3123, 5);
    wb(1'b0, 4'h4, 4'hF, 32'h0);
    chk("overrun", 32'h4, rd & 32'h4);
    wb(1'b1, 4'h4, 4'hF, 32'h4);
    fork
      conv(14'h0777, 400);
      arop_host_i.ext_read(1'b1, w1);
    join
    chk("ext rdc", 32'h3123, {18'h0, w1});
    wb(1'b0, 4'h4, 4'hF, 32'h0);
    chk("no overrun", 32'h0, rd & 32'h4);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("reset oe", 32'h3FFF, {18'h0, d_oe_n});
    rst <= 1'b0;
    wb(1'b0, 4'h0, 4'hF, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    wb(1'b0, 4'h8, 4'hF, 32'h0);
    chk("result reset", 32'h0, rd);
    test_done();
  end
endmodule
